// file: hdl/pieg_consts.vh
`ifndef PIEG_CONSTS_VH
`define PIEG_CONSTS_VH

// Byte addresses of the registers.
`define PIEG_ADDR_ENABLE   12'h08c
`define PIEG_ADDR_FLAG     12'h090
`define PIEG_ADDR_CTRL     12'h094
`define PIEG_ADDR_STATUS   12'h098
`define PIEG_ADDR_MASK     12'h09c

// Reset values.
`define PIEG_RST_ENABLE    8'h00
`define PIEG_RST_FLAG      8'h00
`define PIEG_RST_CTRL      8'h00
`define PIEG_RST_STATUS    8'h00
`define PIEG_RST_MASK      8'h00

// Field positions in core_irq_control.
`define PIEG_BIT_GLOBAL    7
`define PIEG_BIT_GROUP     6

// Source positions, shared by the enable, flag, status and mask layouts.
`define PIEG_SRC_NV_WRITE  7
`define PIEG_SRC_ADC       6
`define PIEG_SRC_CAPCMP    5
`define PIEG_SRC_CMP_B     4
`define PIEG_SRC_CMP_A     3
`define PIEG_SRC_OSC_FAIL  2
`define PIEG_SRC_TMR_B     1
`define PIEG_SRC_TMR_A     0

`define PIEG_NUM_SRC       8

`endif

// file: hdl/pieg_sticky_bit.v
`timescale 1ns/1ps

// Sticky bit: a set in the same cycle as a clear wins, so no event is lost.
module pieg_sticky_bit (
    // Clock and reset
    input  wire pclk,
    input  wire presetn,
    // Control
    input  wire set_i,
    input  wire clr_i,
    // State
    output reg  q_r
);

    reg q_nxt;

    always @* begin
        q_nxt = q_r;
        if (clr_i) begin
            q_nxt = 1'b0;
        end
        if (set_i) begin
            q_nxt = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_r <= 1'b0;
        end else begin
            q_r <= q_nxt;
        end
    end

endmodule

// file: hdl/pieg_top.v
`timescale 1ns/1ps
`include "pieg_consts.vh"

module pieg_top (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output reg         pslverr,
    // Peripheral source events, one-cycle pulses on pclk
    input  wire [7:0]  src_event,
    // Request to the core
    output reg         core_irq_req,
    // Interrupt output of the status and mask pair
    output wire        irq
);

    reg  [7:0] periph_enable_reg_one_r;
    reg  [7:0] core_irq_control_r;
    reg  [7:0] irq_mask_r;
    wire [7:0] periph_flag_reg_one;
    wire [7:0] irq_status;
    wire       setup;
    wire       access;
    wire       wr_en;
    wire       hit;
    wire       global_irq_enable;
    wire       periph_group_enable;
    wire       core_irq_req_nxt;
    reg  [7:0] rd_nxt;
    wire       sel_enable;
    wire       sel_flag;
    wire       sel_ctrl;
    wire       sel_status;
    wire       sel_mask;
    wire       wr_enable;
    wire       wr_flag;
    wire       wr_ctrl;
    wire       wr_mask;
    wire       rd_status;
    wire [7:0] flag_clr;
    wire [7:0] status_clr;
    wire       flag_nv_write_done;
    wire       flag_adc_done;
    wire       flag_capcmp;
    wire       flag_comparator_b;
    wire       flag_comparator_a;
    wire       flag_osc_fail;
    wire       flag_timer_b_match;
    wire       flag_timer_a_overflow;
    wire       nv_write_done_enable;
    wire       adc_done_enable;
    wire       capcmp_enable;
    wire       comparator_b_enable;
    wire       comparator_a_enable;
    wire       osc_fail_enable;
    wire       timer_b_match_enable;
    wire       timer_a_overflow_enable;
    wire [7:0] periph_pending;
    wire       periph_pending_any;

    // The slave never stalls; every access completes in one access cycle.
    assign pready = 1'b1;
    assign setup  = psel & ~penable;
    assign access = psel & penable;
    assign wr_en  = access & pwrite & ~pslverr;

    // One decode per register; an unmapped address selects nothing.
    assign sel_enable = (paddr == `PIEG_ADDR_ENABLE);
    assign sel_flag   = (paddr == `PIEG_ADDR_FLAG);
    assign sel_ctrl   = (paddr == `PIEG_ADDR_CTRL);
    assign sel_status = (paddr == `PIEG_ADDR_STATUS);
    assign sel_mask   = (paddr == `PIEG_ADDR_MASK);
    assign hit        = sel_enable | sel_flag | sel_ctrl | sel_status | sel_mask;

    assign wr_enable  = wr_en & sel_enable;
    assign wr_flag    = wr_en & sel_flag;
    assign wr_ctrl    = wr_en & sel_ctrl;
    assign wr_mask    = wr_en & sel_mask;
    // The error captured at setup qualifies the clearing read, so a refused read clears nothing.
    assign rd_status  = access & ~pwrite & ~pslverr & sel_status;

    assign flag_clr   = {8{wr_flag}} & ~pwdata[7:0];
    // Only bits that the read returned are cleared, so an event that lands
    // between setup and access is kept for the next read.
    assign status_clr = {8{rd_status}} & prdata[7:0];

    always @* begin
        case (paddr)
            `PIEG_ADDR_ENABLE: rd_nxt = periph_enable_reg_one_r;
            `PIEG_ADDR_FLAG:   rd_nxt = periph_flag_reg_one;
            `PIEG_ADDR_CTRL:   rd_nxt = core_irq_control_r;
            `PIEG_ADDR_STATUS: rd_nxt = irq_status;
            `PIEG_ADDR_MASK:   rd_nxt = irq_mask_r;
            default:           rd_nxt = 8'h00;
        endcase
    end

    // Read data and error are captured in the setup cycle so they come from flops.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            prdata <= {24'h00_0000, (pwrite ? 8'h00 : rd_nxt)};
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (setup) begin
            pslverr <= ~hit;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_enable_reg_one_r <= `PIEG_RST_ENABLE;
        end else if (wr_enable) begin
            periph_enable_reg_one_r <= pwdata[7:0];
        end
    end

    // Only the two gate bits are kept; the other bits read as zero.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_irq_control_r <= `PIEG_RST_CTRL;
        end else if (wr_ctrl) begin
            core_irq_control_r <= {pwdata[`PIEG_BIT_GLOBAL], pwdata[`PIEG_BIT_GROUP], 6'h00};
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_r <= `PIEG_RST_MASK;
        end else if (wr_mask) begin
            irq_mask_r <= pwdata[7:0];
        end
    end

    genvar i;
    generate
        for (i = 0; i < `PIEG_NUM_SRC; i = i + 1) begin : g_src
            pieg_sticky_bit u_flag (
                .pclk    (pclk),
                .presetn (presetn),
                .set_i   (src_event[i]),
                .clr_i   (flag_clr[i]),
                .q_r     (periph_flag_reg_one[i])
            );
            pieg_sticky_bit u_status (
                .pclk    (pclk),
                .presetn (presetn),
                .set_i   (src_event[i]),
                .clr_i   (status_clr[i]),
                .q_r     (irq_status[i])
            );
        end
    endgenerate

    assign global_irq_enable   = core_irq_control_r[`PIEG_BIT_GLOBAL];
    assign periph_group_enable = core_irq_control_r[`PIEG_BIT_GROUP];

    assign flag_nv_write_done    = periph_flag_reg_one[`PIEG_SRC_NV_WRITE];
    assign flag_adc_done         = periph_flag_reg_one[`PIEG_SRC_ADC];
    assign flag_capcmp           = periph_flag_reg_one[`PIEG_SRC_CAPCMP];
    assign flag_comparator_b     = periph_flag_reg_one[`PIEG_SRC_CMP_B];
    assign flag_comparator_a     = periph_flag_reg_one[`PIEG_SRC_CMP_A];
    assign flag_osc_fail         = periph_flag_reg_one[`PIEG_SRC_OSC_FAIL];
    assign flag_timer_b_match    = periph_flag_reg_one[`PIEG_SRC_TMR_B];
    assign flag_timer_a_overflow = periph_flag_reg_one[`PIEG_SRC_TMR_A];

    assign nv_write_done_enable    = periph_enable_reg_one_r[`PIEG_SRC_NV_WRITE];
    assign adc_done_enable         = periph_enable_reg_one_r[`PIEG_SRC_ADC];
    assign capcmp_enable           = periph_enable_reg_one_r[`PIEG_SRC_CAPCMP];
    assign comparator_b_enable     = periph_enable_reg_one_r[`PIEG_SRC_CMP_B];
    assign comparator_a_enable     = periph_enable_reg_one_r[`PIEG_SRC_CMP_A];
    assign osc_fail_enable         = periph_enable_reg_one_r[`PIEG_SRC_OSC_FAIL];
    assign timer_b_match_enable    = periph_enable_reg_one_r[`PIEG_SRC_TMR_B];
    assign timer_a_overflow_enable = periph_enable_reg_one_r[`PIEG_SRC_TMR_A];

    assign periph_pending[`PIEG_SRC_NV_WRITE] = flag_nv_write_done & nv_write_done_enable;
    assign periph_pending[`PIEG_SRC_ADC]      = flag_adc_done & adc_done_enable;
    assign periph_pending[`PIEG_SRC_CAPCMP]   = flag_capcmp & capcmp_enable;
    assign periph_pending[`PIEG_SRC_CMP_B]    = flag_comparator_b & comparator_b_enable;
    assign periph_pending[`PIEG_SRC_CMP_A]    = flag_comparator_a & comparator_a_enable;
    assign periph_pending[`PIEG_SRC_OSC_FAIL] = flag_osc_fail & osc_fail_enable;
    assign periph_pending[`PIEG_SRC_TMR_B]    = flag_timer_b_match & timer_b_match_enable;
    assign periph_pending[`PIEG_SRC_TMR_A]    = flag_timer_a_overflow & timer_a_overflow_enable;
    assign periph_pending_any                 = |periph_pending;

    assign core_irq_req_nxt = global_irq_enable & periph_group_enable & periph_pending_any;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_irq_req <= 1'b0;
        end else begin
            core_irq_req <= core_irq_req_nxt;
        end
    end

    assign irq = |(irq_status & irq_mask_r);

endmodule

// file: verif/pieg_sva.sv
`timescale 1ns/1ps
`include "pieg_consts.vh"
module pieg_sva (
    // Clock and reset
    input wire        pclk,
    input wire        presetn,
    // APB
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire        pready,
    input wire [31:0] prdata,
    input wire        pslverr,
    // Events and requests
    input wire [7:0]  src_event,
    input wire        core_irq_req,
    input wire        irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr  = psel && penable && pwrite;
    wire hit = paddr == `PIEG_ADDR_ENABLE || paddr == `PIEG_ADDR_FLAG || paddr == `PIEG_ADDR_CTRL
               || paddr == `PIEG_ADDR_STATUS || paddr == `PIEG_ADDR_MASK;
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_data_upper: assert property (prdata[31:8] == 24'h000000)
        else $error("prdata upper bits set");
    a_map_error: assert property (psel && !penable |=> pslverr == !hit)
        else $error("pslverr wrong");
    a_data_stands: assert property (!psel |=> $stable(prdata))
        else $error("prdata moved while idle");
    // The request is registered, so its cause lies two edges back.
    a_req_cause: assert property ($rose(core_irq_req) |-> $past(|src_event, 2) || $past(wr, 2))
        else $error("request rose without cause");
    a_req_hold: assert property ($fell(core_irq_req) |-> $past(wr, 2))
        else $error("request fell without write");
    a_irq_cause: assert property ($rose(irq) |-> $past(|src_event) || $past(wr))
        else $error("irq rose without cause");
    a_irq_hold: assert property ($fell(irq) |-> $past(psel && penable))
        else $error("irq fell without access");
    c_req: cover property ($rose(core_irq_req));
    c_irq: cover property ($fell(irq));
    c_err: cover property (pslverr);
endmodule
bind pieg_top pieg_sva pieg_sva_i (.*);

// file: verif/pieg_periph.sv
`timescale 1ns/1ps
module pieg_periph (
    // Clock
    input  wire        pclk,
    // Source events
    output logic [7:0] src_event
);
    initial src_event = 8'h00;
    task pulse(input logic [7:0] m);
        @(posedge pclk);
        src_event <= m;
        @(posedge pclk);
        src_event <= 8'h00;
    endtask
endmodule

// file: verif/tb_top.sv
`timescale 1ns/1ps
`include "pieg_consts.vh"
module tb_top;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, qe;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, q, pat[2] = '{32'ha5, 32'h5a}, cv[3] = '{32'h40, 32'h80, 32'hc0};
    wire         pready, pslverr, core_irq_req, irq;
    wire  [31:0] prdata;
    wire  [7:0]  src_event;
    int          fail_count = 0, n_checks = 0;
    always #20 pclk = ~pclk;
    pieg_periph pieg_periph_i (.*);
    pieg_top pieg_top_i (.*);
    task chk(input logic [31:0] s, e);
        n_checks++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task xf(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        qe = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task w2;
        repeat (2) @(posedge pclk);
        #1;
    endtask
    task test_done;
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge pclk);
        fail_count++;
        test_done;
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        xf(0, `PIEG_ADDR_ENABLE, 0);
        chk(q, `PIEG_RST_ENABLE);
        xf(0, 12'h0f0, 0);
        chk(qe, 1);
        foreach (pat[i]) begin
            xf(1, `PIEG_ADDR_ENABLE, pat[i]);
            xf(0, `PIEG_ADDR_ENABLE, 0);
            chk(q, pat[i]);
        end
        pieg_periph_i.pulse(8'hff);
        repeat (20) @(posedge pclk);
        chk(core_irq_req, 0);
        xf(0, `PIEG_ADDR_FLAG, 0);
        chk(q, 32'hff);
        xf(1, `PIEG_ADDR_FLAG, 32'h0f);
        xf(0, `PIEG_ADDR_FLAG, 0);
        chk(q, 32'h0f);
        xf(1, `PIEG_ADDR_FLAG, 0);
        xf(1, `PIEG_ADDR_CTRL, 32'hc0);
        for (int i = 0; i < 8; i++) begin
            xf(1, `PIEG_ADDR_ENABLE, 32'h1 << i);
            pieg_periph_i.pulse(~(8'h1 << i));
            w2;
            chk(core_irq_req, 0);
            pieg_periph_i.pulse(8'h1 << i);
            w2;
            chk(core_irq_req, 1);
            xf(1, `PIEG_ADDR_FLAG, 0);
        end
        pieg_periph_i.pulse(8'h80);
        foreach (cv[i]) begin
            xf(1, `PIEG_ADDR_CTRL, cv[i]);
            w2;
            chk(core_irq_req, cv[i] == 32'hc0);
        end
        xf(1, `PIEG_ADDR_CTRL, 32'hff);
        xf(0, `PIEG_ADDR_CTRL, 0);
        chk(q, 32'hc0);
        xf(0, `PIEG_ADDR_STATUS, 0);
        xf(1, `PIEG_ADDR_MASK, 32'h01);
        pieg_periph_i.pulse(8'h02);
        w2;
        chk(irq, 0);
        pieg_periph_i.pulse(8'h01);
        w2;
        chk(irq, 1);
        xf(0, `PIEG_ADDR_STATUS, 0);
        chk(q, 32'h03);
        w2;
        chk(irq, 0);
        test_done;
    end
endmodule
